/* rtl/spac_top.sv */
// Serial port with audio formats, Wishbone registers and two FIFOs
// ---------------------------------------------------------------
// Notes on behaviour
// - Master drives bit clock, slave follows it
// - Idle polarity and sample edge select format
// - Framed mode marks each word start
// - Word width is 8, 16 or 32 bits
// - Separate FIFOs, depth 16/8/4 by width
// - Optional event on every finished word
// - Runs regardless of processor low-power states
// - Receive read sign-extends when enabled, else zero-fills
// - Frame error event only when enabled
// - Receive overflow event only when enabled
// - Transmit underrun event only when enabled
// - Ignored overflow keeps FIFO, otherwise halts
// - Ignored underrun sends zeros, otherwise halts
// - Audio enable selects codec protocol operation
// - Mono sends each word on both channels
// - Format 00 I2S, 01 LJ, 10 RJ, 11 PCM
// - Audio bits writable only while port off
// - Mono and format count only in audio mode
// - Unused control-two bits read zero
// ---------------------------------------------------------------
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "spac_defs.svh"
module spac_top import spac_pkg::*; (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial link pins
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  input  wire logic        fs_i,
  output logic             fs_o,
  output logic             fs_oe_o,
  // Events
  output logic             err_irq_o,
  output logic             word_evt_o
);
  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  typedef struct packed {
    spac_state_type st;
    logic [15:0]    ctrl;
    logic [15:0]    ctrl2;
    logic           rx_overflow;
    logic           tx_underrun;
    logic           ferr;
    logic           sck;
    logic           sck_oe;
    logic           sck_prev;
    logic           fs;
    logic           fs_oe;
    logic [7:0]     divc;
    logic [31:0]    tx_sr;
    logic [31:0]    rx_sr;
    logic [31:0]    last_tx;
    logic [5:0]     bits;
    logic           need_load;
    logic           chan;
    logic           ack;
    logic [31:0]    rdat;
    logic           irq;
    logic           evt;
  } spac_regs_type;
  spac_regs_type q, d;

  // Synchronised pins and FIFO handshakes
  logic        sck_s, sdi_s, fs_s;
  logic        tx_push, tx_ready, tx_ne, tx_pop;
  logic        rx_push, rx_ready, rx_ne, rx_pop;
  logic [31:0] tx_rd, rx_rd, rx_wd;
  logic [4:0]  lim;

  // Decoded controls
  logic         on, master, idle, phase, framed, audio, mono;
  logic [1:0]   wmode;
  logic [5:0]   wbits;
  logic [7:0]   div;
  spac_fmt_type fmt;
  logic         req, lvl, go, tick, lead, trail, smp, shf;
  logic         imm, load, done;
  logic [31:0]  word, wmask;

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Left-align a word so the first bit out is always bit 31
  function automatic logic [31:0] align(input logic [31:0] w,
                                        input logic [1:0]  m);
    case (m)
      2'b00:   align = {w[7:0], 24'h000000};
      2'b01:   align = {w[15:0], 16'h0000};
      default: align = w;
    endcase
  endfunction

  // Receive word as software sees it
  function automatic logic [31:0] extend(input logic [31:0] w,
                                         input logic [1:0]  m,
                                         input logic        s);
    case (m)
      2'b00:   extend = {{24{s & w[7]}}, w[7:0]};
      2'b01:   extend = {{16{s & w[15]}}, w[15:0]};
      default: extend = w;
    endcase
  endfunction

  // -------------------------------------------------------------
  // Submodules
  // -------------------------------------------------------------
  // Link clock is sampled, not used as a clock
  spac_sync #(.W(3)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .a_i   ({sck_i, sdi_i, fs_i}),
    .s_o   ({sck_s, sdi_s, fs_s})
  );

  spac_fifo #(.DW(32), .DEPTH(16)) u_txf (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clear_i    (~on),
    .lim_i      (lim),
    .wr_valid_i (tx_push),
    .wr_data_i  (wb_dat_i),
    .wr_ready_o (tx_ready),
    .rd_valid_o (tx_ne),
    .rd_data_o  (tx_rd),
    .rd_ready_i (tx_pop)
  );

  spac_fifo #(.DW(32), .DEPTH(16)) u_rxf (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clear_i    (~on),
    .lim_i      (lim),
    .wr_valid_i (rx_push),
    .wr_data_i  (rx_wd),
    .wr_ready_o (rx_ready),
    .rd_valid_o (rx_ne),
    .rd_data_o  (rx_rd),
    .rd_ready_i (rx_pop)
  );

  // -------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------
  assign on     = q.ctrl[`SPAC_C_ON];
  assign master = q.ctrl[`SPAC_C_MASTER];
  assign idle   = q.ctrl[`SPAC_C_IDLEHI];
  assign phase  = q.ctrl[`SPAC_C_PHASE];
  assign framed = q.ctrl[`SPAC_C_FRAME];
  assign wmode  = q.ctrl[`SPAC_C_WM_HI:`SPAC_C_WM_LO];
  assign div    = q.ctrl[`SPAC_C_DV_HI:`SPAC_C_DV_LO];
  assign audio  = q.ctrl2[`SPAC_C2_AUD];
  // Audio sub-settings are dead outside audio mode
  assign mono   = audio & q.ctrl2[`SPAC_C2_MONO];
  assign fmt    = spac_fmt_type'(audio ?
                  q.ctrl2[`SPAC_C2_FM_HI:`SPAC_C2_FM_LO] : 2'b00);

  // Word width and matching FIFO depth
  always_comb begin
    case (wmode)
      2'b00: begin
        wbits = `SPAC_WB8;
        lim   = `SPAC_D8;
      end
      2'b01: begin
        wbits = `SPAC_WB16;
        lim   = `SPAC_D16;
      end
      default: begin
        wbits = `SPAC_WB32;
        lim   = `SPAC_D32;
      end
    endcase
  end

  // -------------------------------------------------------------
  // Bit clock edges
  // -------------------------------------------------------------
  // Master waits at a word boundary; first bit settles before its edge
  assign go    = ~(q.need_load & (q.sck == idle) & (imm | ~(tx_ne | audio)));
  assign tick  = master & (q.st == SPAC_ST_RUN) & go & (q.divc == div);
  assign lvl   = master ? q.sck : sck_s;
  assign lead  = master ? tick & (q.sck == idle)
               : (sck_s != q.sck_prev) & (q.sck_prev == idle);
  assign trail = master ? tick & (q.sck != idle)
               : (sck_s != q.sck_prev) & (q.sck_prev != idle);
  // Phase picks which edge samples and which shifts
  assign smp   = (q.st == SPAC_ST_RUN) & (phase ? trail : lead);
  assign shf   = (q.st == SPAC_ST_RUN) & (phase ? lead : trail);
  // With leading-edge sampling the first bit must be out early
  assign imm   = ~phase & (lvl == idle) & (q.bits == 6'h00) & tx_ne;
  assign load  = (q.st == SPAC_ST_RUN) & q.need_load & (shf | imm);
  assign done  = smp & ((q.bits + 6'h01) == wbits);
  assign rx_wd = {q.rx_sr[30:0], sdi_s};
  assign req   = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    d          = q;
    d.ack      = req;
    d.evt      = 1'b0;
    d.sck_prev = sck_s;
    tx_push    = 1'b0;
    tx_pop     = 1'b0;
    rx_push    = 1'b0;
    rx_pop     = 1'b0;
    word       = 32'h00000000;

    // Bus access, answered on the next edge
    if (req) begin
      d.rdat = 32'h00000000;
      case (wb_adr_i)
        `SPAC_A_CTRL: begin
          d.rdat = {16'h0000, q.ctrl};
          if (wb_we_i) begin
            d.ctrl = (q.ctrl & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
          end
        end
        `SPAC_A_CTRL2: begin
          d.rdat = {16'h0000, q.ctrl2};
          if (wb_we_i) begin
            // Audio bits frozen while the port runs
            d.ctrl2 = (q.ctrl2 & ~(wmask[15:0] & `SPAC_C2_MASK
                      & (on ? ~`SPAC_C2_LOCK : 16'hffff)))
                    | (wb_dat_i[15:0] & wmask[15:0] & `SPAC_C2_MASK
                      & (on ? ~`SPAC_C2_LOCK : 16'hffff));
          end
        end
        `SPAC_A_STAT: begin
          d.rdat[`SPAC_S_ROV]    = q.rx_overflow;
          d.rdat[`SPAC_S_TUR]    = q.tx_underrun;
          d.rdat[`SPAC_S_FERR]   = q.ferr;
          d.rdat[`SPAC_S_RXNE]   = rx_ne;
          d.rdat[`SPAC_S_TXFULL] = ~tx_ready;
          d.rdat[`SPAC_S_HALT]   = (q.st == SPAC_ST_HALT);
          d.rdat[`SPAC_S_BUSY]   = ~q.need_load | (q.bits != 6'h00);
          // Write one to clear; a same-cycle event wins below
          if (wb_we_i & wb_sel_i[0]) begin
            d.rx_overflow  = q.rx_overflow & ~wb_dat_i[`SPAC_S_ROV];
            d.tx_underrun  = q.tx_underrun & ~wb_dat_i[`SPAC_S_TUR];
            d.ferr = q.ferr & ~wb_dat_i[`SPAC_S_FERR];
          end
        end
        `SPAC_A_DATA: begin
          if (wb_we_i) begin
            tx_push = 1'b1;                             // dropped if full
          end else begin
            rx_pop = rx_ne;
            d.rdat = extend(rx_rd, wmode,
                            q.ctrl2[`SPAC_C2_SEXT]);
          end
        end
        default: d.rdat = 32'h00000000;
      endcase
    end

    // Master bit clock divider
    if (master & (q.st == SPAC_ST_RUN) & go) begin
      d.divc = (q.divc == div) ? 8'h00 : q.divc + 8'h01;
    end
    if (tick) begin
      d.sck = ~q.sck;
    end

    // Transmit side: load a word or shift one bit
    if (load) begin
      d.need_load = 1'b0;
      if (mono & q.chan) begin
        word = q.last_tx;
      end else if (tx_ne) begin
        tx_pop = 1'b1;
        word   = tx_rd;
      end else if (master & ~audio) begin
        d.need_load = 1'b1;                             // wait, no error
      end else begin
        d.tx_underrun = 1'b1;
        word  = 32'h00000000;
        if (~q.ctrl2[`SPAC_C2_IGUR]) begin
          d.st = SPAC_ST_HALT;
        end
      end
      if (~d.need_load) begin
        d.tx_sr   = align(word, wmode);
        d.last_tx = word;
      end
    end else if (shf) begin
      d.tx_sr = {q.tx_sr[30:0], 1'b0};
    end

    // Receive side: sample one bit, close the word
    if (smp) begin
      d.rx_sr = rx_wd;
      d.bits  = q.bits + 6'h01;
      // Slave in framed mode checks the word mark
      if (framed & ~master & ~audio &
          ((q.bits == 6'h00) != fs_s)) begin
        d.ferr = 1'b1;
      end
    end
    if (done) begin
      d.bits      = 6'h00;
      d.need_load = 1'b1;
      d.evt       = q.ctrl[`SPAC_C_EVTEN];
      d.chan      = audio & ~q.chan;
      if (rx_ready) begin
        rx_push = 1'b1;
      end else begin
        // New word dropped, stored words kept
        d.rx_overflow = 1'b1;
        if (~q.ctrl2[`SPAC_C2_IGOV]) begin
          d.st = SPAC_ST_HALT;
        end
      end
    end

    // Frame sync drive for master
    case (fmt)
      SPAC_FMT_I2S: d.fs = audio & d.chan;
      SPAC_FMT_LJ:  d.fs = ~d.chan;
      SPAC_FMT_RJ:  d.fs = ~d.chan;
      SPAC_FMT_PCM: d.fs = ~d.chan & (d.bits == 6'h00) & ~d.need_load;
      default:      d.fs = 1'b0;
    endcase
    if (~audio) begin
      d.fs = framed & (d.bits == 6'h00) & ~d.need_load;
    end
    d.fs_oe  = master & on & (framed | audio);
    d.sck_oe = master & on;

    // Engine state; no sleep input gates it
    case (q.st)
      SPAC_ST_IDLE: begin
        d.sck       = idle;
        d.divc      = 8'h00;
        d.bits      = 6'h00;
        d.need_load = 1'b1;
        d.chan      = 1'b0;
        d.tx_sr     = 32'h00000000;
        if (on) begin
          d.st = SPAC_ST_RUN;
        end
      end
      SPAC_ST_RUN: begin
        if (~on) begin
          d.st = SPAC_ST_IDLE;
        end
      end
      SPAC_ST_HALT: begin
        d.sck = idle;
        if (~on) begin
          d.st = SPAC_ST_IDLE;
        end
      end
      default: d.st = SPAC_ST_IDLE;
    endcase

    // One error request from the enabled sticky flags
    d.irq = (d.ferr & q.ctrl2[`SPAC_C2_FEEN])
          | (d.rx_overflow & q.ctrl2[`SPAC_C2_OVEN])
          | (d.tx_underrun & q.ctrl2[`SPAC_C2_UREN]);
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q     <= '0;
      q.st  <= SPAC_ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // All outputs straight from flops
  assign wb_ack_o   = q.ack;
  assign wb_dat_o   = q.rdat;
  assign sck_o      = q.sck;
  assign sck_oe_o   = q.sck_oe;
  assign sdo_o      = q.tx_sr[31];
  assign fs_o       = q.fs;
  assign fs_oe_o    = q.fs_oe;
  assign err_irq_o  = q.irq;
  assign word_evt_o = q.evt;
endmodule

/* rtl/spac_defs.svh */
// Register map, bit positions and sizes of the serial audio port
`ifndef SPAC_DEFS_SVH
`define SPAC_DEFS_SVH
// Word offsets on the bus
`define SPAC_A_CTRL   8'h00
`define SPAC_A_CTRL2  8'h04
`define SPAC_A_STAT   8'h08
`define SPAC_A_DATA   8'h0c
// Main control register fields
`define SPAC_C_ON     0
`define SPAC_C_MASTER 1
`define SPAC_C_IDLEHI 2
`define SPAC_C_PHASE  3
`define SPAC_C_FRAME  4
`define SPAC_C_EVTEN  5
`define SPAC_C_WM_LO  6
`define SPAC_C_WM_HI  7
`define SPAC_C_DV_LO  8
`define SPAC_C_DV_HI  15
// Second control register fields
`define SPAC_C2_SEXT  15
`define SPAC_C2_FEEN  12
`define SPAC_C2_OVEN  11
`define SPAC_C2_UREN  10
`define SPAC_C2_IGOV  9
`define SPAC_C2_IGUR  8
`define SPAC_C2_AUD   7
`define SPAC_C2_MONO  3
`define SPAC_C2_FM_LO 0
`define SPAC_C2_FM_HI 1
`define SPAC_C2_MASK  16'h9f8b
`define SPAC_C2_LOCK  16'h008b
// Status register fields
`define SPAC_S_ROV    0
`define SPAC_S_TUR    1
`define SPAC_S_FERR   2
`define SPAC_S_RXNE   3
`define SPAC_S_TXFULL 4
`define SPAC_S_HALT   5
`define SPAC_S_BUSY   6
// Word widths in bits and FIFO depths per width
`define SPAC_WB8      6'h08
`define SPAC_WB16     6'h10
`define SPAC_WB32     6'h20
`define SPAC_D8       5'h10
`define SPAC_D16      5'h08
`define SPAC_D32      5'h04
`endif

/* rtl/spac_pkg.sv */
// Types shared by the serial audio port modules
package spac_pkg;
  // Port engine states, one-hot
  typedef enum logic [2:0] {
    SPAC_ST_IDLE = 3'b001,
    SPAC_ST_RUN  = 3'b010,
    SPAC_ST_HALT = 3'b100
  } spac_state_type;
  // Audio formats
  typedef enum logic [1:0] {
    SPAC_FMT_I2S = 2'b00,
    SPAC_FMT_LJ  = 2'b01,
    SPAC_FMT_RJ  = 2'b10,
    SPAC_FMT_PCM = 2'b11
  } spac_fmt_type;
endpackage

/* rtl/spac_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module spac_sync import spac_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Async in, synced out
  input  wire logic [W-1:0] a_i,
  output logic      [W-1:0] s_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spac_sync_type;
  spac_sync_type q, d;

  // First stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = a_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_o = q.s2;
endmodule

/* rtl/spac_fifo.sv */
// Word FIFO whose usable depth follows the selected word width
`timescale 1ns/1ps
module spac_fifo import spac_pkg::*; #(
  parameter int DW    = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Control
  input  wire logic          clear_i,
  input  wire logic [4:0]    lim_i,
  // Fill side
  input  wire logic          wr_valid_i,
  input  wire logic [DW-1:0] wr_data_i,
  output logic               wr_ready_o,
  // Drain side
  output logic               rd_valid_o,
  output logic [DW-1:0]      rd_data_o,
  input  wire logic          rd_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW-1:0]            wp;
    logic [AW-1:0]            rp;
    logic [4:0]               cnt;
  } spac_fifo_type;
  spac_fifo_type q, d;
  logic wr, rd;

  // Capacity is the width-dependent limit, not the array size
  assign wr_ready_o = (q.cnt < lim_i);
  assign rd_valid_o = (q.cnt != 5'h00);
  assign rd_data_o  = q.mem[q.rp];
  assign wr = wr_valid_i & wr_ready_o;
  assign rd = rd_ready_i & rd_valid_o;

  // Pointer and count update
  always_comb begin
    d = q;
    if (wr) begin
      d.mem[q.wp] = wr_data_i;
      d.wp        = q.wp + 1'b1;
    end
    if (rd) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + {4'h0, wr} - {4'h0, rd};
    if (clear_i) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = 5'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

/* tb/spac_top_asserts.sv */
// Port-level checks of the serial audio port bus and event outputs
`timescale 1ns/1ps
`include "spac_defs.svh"
module spac_top_asserts import spac_pkg::*; (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Link enables and events
  input wire logic        sck_oe_o,
  input wire logic        fs_oe_o,
  input wire logic        err_irq_o,
  input wire logic        word_evt_o
);
  // ---------------------------------------------------------------
  // Bus request and clocking
  // ---------------------------------------------------------------
  logic req;
  assign req = wb_cyc_i && wb_stb_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  AST_ACK_ONE: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack late after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  AST_CTRL2_ZERO: assert property (req && !wb_we_i && !wb_ack_o &&
    wb_adr_i == `SPAC_A_CTRL2 |=> (wb_dat_o & ~32'h00009f8b) == 32'h0)
    else $error("unused control two bit reads one");
  AST_UNMAPPED: assert property (req && !wb_we_i && !wb_ack_o &&
    wb_adr_i > `SPAC_A_DATA |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_FS_OE: assert property (fs_oe_o |-> sck_oe_o)
    else $error("frame out driven outside master");
  AST_EVT_PULSE: assert property (word_evt_o |=> !word_evt_o)
    else $error("word event not a pulse");
  // Sticky request only drops after a register write
  AST_IRQ_HOLD: assert property ($fell(err_irq_o) && !$past(rst_i)
    |-> $past(req && wb_we_i))
    else $error("error request dropped without write");
endmodule
bind spac_top spac_top_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sck_oe_o(sck_oe_o), .fs_oe_o(fs_oe_o),
  .err_irq_o(err_irq_o), .word_evt_o(word_evt_o));

/* tb/spac_peer.sv */
// Remote serial party that clocks frames into the port as its master
`timescale 1ns/1ps
module spac_peer (
  // Link pins
  output logic      sck_o,
  output logic      sd_o,
  output logic      fs_o,
  input  wire logic sd_i
);
  // Bits seen on the port's data out
  logic [31:0] rx_q;
  // Frame mark on the first bit when set
  logic        frm;
  initial begin
    sck_o = 1'b0;
    sd_o = 1'b0;
    fs_o = 1'b0;
    frm = 1'b0;
    rx_q = 32'h0;
  end
  // One frame MSB first; clock idles low and stops between frames
  task automatic send(input logic [31:0] w, input int n);
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      sd_o = w[i];
      fs_o = frm & (i == n - 1);
      #100 sck_o = 1'b1;
      rx_q = {rx_q[30:0], sd_i};
      #100 sck_o = 1'b0;
    end
    // Released line flips so a stale level cannot pass
    sd_o = ~sd_o;
    #400;
  endtask
endmodule

/* tb/serial_port_audio_control_tb.sv */
// Self-checking bench for the serial audio port
`timescale 1ns/1ps
`include "spac_defs.svh"
module serial_port_audio_control_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, mo_q;
  logic        sck_o, sck_oe_o, sdo_o, fs_o, fs_oe_o, err_irq_o;
  logic        word_evt_o, peer_sck, peer_sd, peer_fs, sck_w;
  int          n_fail, samples_checked, n_evt, n_sck, n_fs;
  // Master loops its own clock back; slave follows the peer
  assign sck_w = sck_oe_o ? sck_o : peer_sck;
  spac_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdi_i(peer_sd), .sdo_o(sdo_o), .fs_i(peer_fs),
    .fs_o(fs_o), .fs_oe_o(fs_oe_o), .err_irq_o(err_irq_o),
    .word_evt_o(word_evt_o));
  spac_peer u_peer (.sck_o(peer_sck), .sd_o(peer_sd), .fs_o(peer_fs),
    .sd_i(sdo_o));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Event and bit clock counters
  always @(posedge clk_i) if (word_evt_o === 1'b1) n_evt++;
  // Master data taken on its own rising clock, where it does not move
  always @(posedge sck_o) begin
    n_sck++;
    mo_q = {mo_q[30:0], sdo_o};
  end
  always @(posedge fs_o) n_fs++;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle; read data taken at the ack edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) n_fail++;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask
  task automatic summarize;
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {n_fail, samples_checked, n_evt, n_sck, n_fs} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unused bits, lock of audio bits while on
    rc(`SPAC_A_CTRL2, 32'hffffffff, 32'h0);
    rc(8'h10, 32'hffffffff, 32'h0);
    wb(1'b1, `SPAC_A_CTRL2, 32'hffffffff);
    rc(`SPAC_A_CTRL2, 32'hffffffff, 32'h00009f8b);
    wb(1'b1, `SPAC_A_CTRL, 32'h1);
    wb(1'b1, `SPAC_A_CTRL2, 32'h0);
    rc(`SPAC_A_CTRL2, 32'hffffffff, 32'h0000008b);
    wb(1'b1, `SPAC_A_CTRL, 32'h0);
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, `SPAC_A_CTRL2, 32'h80 | 32'(f));
      rc(`SPAC_A_CTRL2, 32'hffffffff, 32'h80 | 32'(f));
    end
    // Slave bytes: sign extension, zero fill, tolerated underrun
    wb(1'b1, `SPAC_A_CTRL2, 32'h8300);
    wb(1'b1, `SPAC_A_CTRL, 32'h21);
    u_peer.send(32'h85, 8);
    rc(`SPAC_A_DATA, 32'hffffffff, 32'hffffff85);
    chk(u_peer.rx_q & 32'hff, 32'h0);
    wb(1'b1, `SPAC_A_CTRL2, 32'h0300);
    u_peer.send(32'h85, 8);
    rc(`SPAC_A_DATA, 32'hffffffff, 32'h85);
    rc(`SPAC_A_STAT, 32'h22, 32'h02);
    chk({31'h0, err_irq_o}, 32'h0);
    chk(32'(n_evt), 32'h2);
    // Five words into a four deep FIFO, overflow tolerated
    wb(1'b1, `SPAC_A_CTRL, 32'h0);
    wb(1'b1, `SPAC_A_STAT, 32'h7);
    wb(1'b1, `SPAC_A_CTRL2, 32'h0b00);
    wb(1'b1, `SPAC_A_CTRL, 32'hc1);
    for (int k = 0; k < 5; k++) u_peer.send(32'h800000a0 + 32'(k), 32);
    rc(`SPAC_A_STAT, 32'h29, 32'h09);
    chk({31'h0, err_irq_o}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      rc(`SPAC_A_DATA, 32'hffffffff, 32'h800000a0 + 32'(k));
    end
    rc(`SPAC_A_STAT, 32'h08, 32'h0);
    chk(u_peer.rx_q, 32'h0);
    wb(1'b1, `SPAC_A_STAT, 32'h1);
    rc(`SPAC_A_STAT, 32'h1, 32'h0);
    chk({31'h0, err_irq_o}, 32'h0);
    // Framed slave: mark on the first bit, then a missing mark
    wb(1'b1, `SPAC_A_CTRL, 32'h0);
    wb(1'b1, `SPAC_A_CTRL2, 32'h1100);
    wb(1'b1, `SPAC_A_CTRL, 32'h11);
    u_peer.frm = 1'b1;
    u_peer.send(32'h5a, 8);
    rc(`SPAC_A_DATA, 32'hffffffff, 32'h5a);
    rc(`SPAC_A_STAT, 32'h4, 32'h0);
    chk({31'h0, err_irq_o}, 32'h0);
    u_peer.frm = 1'b0;
    u_peer.send(32'h5a, 8);
    rc(`SPAC_A_STAT, 32'h4, 32'h4);
    chk({31'h0, err_irq_o}, 32'h1);
    // Critical underrun halts until the port is cycled
    wb(1'b1, `SPAC_A_CTRL, 32'h0);
    wb(1'b1, `SPAC_A_STAT, 32'h7);
    wb(1'b1, `SPAC_A_CTRL2, 32'h0400);
    wb(1'b1, `SPAC_A_CTRL, 32'h1);
    u_peer.send(32'h3c, 8);
    rc(`SPAC_A_STAT, 32'h22, 32'h22);
    chk({31'h0, err_irq_o}, 32'h1);
    wb(1'b1, `SPAC_A_STAT, 32'h7);
    rc(`SPAC_A_STAT, 32'h20, 32'h20);
    wb(1'b1, `SPAC_A_CTRL, 32'h0);
    wb(1'b1, `SPAC_A_CTRL, 32'h1);
    rc(`SPAC_A_STAT, 32'h20, 32'h0);
    // Master sends one byte on its own clock
    wb(1'b1, `SPAC_A_CTRL, 32'h0);
    wb(1'b1, `SPAC_A_CTRL2, 32'h0);
    n_sck = 0;
    n_fs = 0;
    wb(1'b1, `SPAC_A_CTRL, 32'h13);
    wb(1'b1, `SPAC_A_DATA, 32'ha5);
    chk({31'h0, sck_oe_o}, 32'h1);
    chk({31'h0, fs_oe_o}, 32'h1);
    for (int i = 0; i < 100; i++) begin
      wb(1'b0, `SPAC_A_STAT, 32'h0);
      if (q[`SPAC_S_BUSY] === 1'b0) break;
    end
    chk(32'(n_sck), 32'h8);
    chk(32'(n_fs), 32'h1);
    chk(mo_q & 32'hff, 32'ha5);
    summarize;
  end
  // Hang guard, several times the expected run
  initial begin
    #500000;
    n_fail++;
    summarize;
  end
endmodule
